// >>> iee_consts.vh
// constants for the incremental encoder evaluation block
`ifndef IEE_CONSTS_VH
`define IEE_CONSTS_VH
// -----------------------------------------------------------------
// clock and filter timing
// -----------------------------------------------------------------
`define IEE_CLK_HZ 50000000
`define IEE_FLT_SHORT_NS 2500
`define IEE_FLT_LONG_NS 25000
`define IEE_FLT_SHORT_CYC ((`IEE_FLT_SHORT_NS * (`IEE_CLK_HZ / 1000000) + 999) / 1000)
`define IEE_FLT_LONG_CYC ((`IEE_FLT_LONG_NS * (`IEE_CLK_HZ / 1000000) + 999) / 1000)
`define IEE_FLT_CNT_W 11
// -----------------------------------------------------------------
// register word addresses
// -----------------------------------------------------------------
`define IEE_REG_CONFIG 4'h0
`define IEE_REG_STATUS 4'h1
`define IEE_REG_IRQ_STAT 4'h2
`define IEE_REG_IRQ_MASK 4'h3
// -----------------------------------------------------------------
// config field positions
// -----------------------------------------------------------------
`define IEE_CFG_EVAL_LSB 0
`define IEE_CFG_FLT_A 2
`define IEE_CFG_FLT_B 3
`define IEE_CFG_FLT_DI 4
`define IEE_CFG_DIR_INV 5
`define IEE_CFG_FUNC_LSB 6
`define IEE_CFG_SYNC_PER 8
`define IEE_CFG_GATE_INV 9
`define IEE_CFG_STOP_CONT 10
`define IEE_CFG_W 11
`define IEE_CFG_RESET 11'h000
// -----------------------------------------------------------------
// encodings
// -----------------------------------------------------------------
`define IEE_EVAL_PULSE_DIR 2'h0
`define IEE_EVAL_SINGLE 2'h1
`define IEE_EVAL_DOUBLE 2'h2
`define IEE_EVAL_QUAD 2'h3
`define IEE_FUNC_INPUT 2'h0
`define IEE_FUNC_GATE 2'h1
`define IEE_FUNC_LATCH 2'h2
`define IEE_FUNC_SYNC 2'h3
// irq bit positions: 0 up, 1 down, 2 latch, 3 sync, 4 param error
`define IEE_IRQ_W 5
`endif

// >>> iee_filter.v
// synchroniser and minimum pulse width filter for one input
`timescale 1ns/1ns
module iee_filter #(
   parameter CNT_W = 11
) (
   input wire ref_clk,            // module clock
   input wire sys_rst,            // synchronous reset, active high
   input wire pin,                // raw asynchronous input
   input wire [CNT_W-1:0] hold,   // cycles a new level must hold
   output reg level               // filtered level
);
   reg sync1;
   reg sync2;
   reg sync3;
   reg [CNT_W-1:0] cnt;
   // -----------------------------------------------------------------
   // three stage synchroniser then hold counter
   // -----------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         cnt <= {CNT_W{1'b0}};
         level <= 1'b0;
      end
      else
      begin
         sync1 <= pin;
         sync2 <= sync1;
         sync3 <= sync2;
         // level accepted only when stages two and three agree long enough
         if (sync2 != sync3 || sync3 == level)
            cnt <= {CNT_W{1'b0}};
         else if (cnt + 1'b1 >= hold)
         begin
            level <= sync3;
            cnt <= {CNT_W{1'b0}};
         end
         else
            cnt <= cnt + 1'b1;
      end
   end
endmodule // iee_filter

// >>> iee_encoder_eval.v
// incremental encoder evaluation top with avalon-mm register slave
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "iee_consts.vh"
module iee_encoder_eval #(
   parameter CNT_W = `IEE_FLT_CNT_W
) (
   input wire ref_clk,               // 50 MHz clock
   input wire sys_rst,               // synchronous reset, active high
   input wire track_a,               // encoder track A pin
   input wire track_b,               // encoder track B pin
   input wire aux_digital_input,     // auxiliary digital input pin
   input wire master_stop,           // controlling master stopped
   input wire [3:0] avs_address,     // word address
   input wire avs_read,              // read strobe
   input wire avs_write,             // write strobe
   input wire [31:0] avs_writedata,  // write data
   output reg [31:0] avs_readdata,   // read data
   output reg avs_waitrequest,       // stall until answer
   output reg count_up,              // one-cycle up count pulse
   output reg count_down,            // one-cycle down count pulse
   output reg hardware_gate,         // gate open level
   output reg latch_pulse,           // latch and retrigger pulse
   output reg sync_pulse,            // synchronisation pulse
   output reg param_assign_error,    // parameter assignment error flag
   output reg irq                    // level interrupt
);
   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   reg [`IEE_CFG_W-1:0] config_reg;
   reg [`IEE_IRQ_W-1:0] irq_stat;
   reg [`IEE_IRQ_W-1:0] irq_mask;
   reg a_q;
   reg b_q;
   reg di_q;
   reg sync_done;
   reg bus_busy;
   reg next_up;
   reg next_down;
   reg dir_down;
   reg [31:0] next_readdata;
   wire a_f;
   wire b_f;
   wire di_f;
   wire [1:0] eval_mode;
   wire [1:0] di_func;
   wire gate_inv;
   wire b_eff;
   wire a_rise;
   wire a_fall;
   wire b_edge;
   wire di_rise;
   wire cfg_bad;
   wire wr_cfg;
   wire rd_stat;
   wire [`IEE_IRQ_W-1:0] events;
   wire stopped_off;

   // filter hold count from select bit
   function [CNT_W-1:0] hold_cycles;
      input sel_long;
      reg [31:0] full;
      begin
         if (sel_long)
            full = `IEE_FLT_LONG_CYC;
         else
            full = `IEE_FLT_SHORT_CYC;
         hold_cycles = full[CNT_W-1:0];
      end
   endfunction

   // parameter check for a candidate configuration
   function cfg_invalid;
      input [`IEE_CFG_W-1:0] cfg;
      begin
         cfg_invalid = cfg[`IEE_CFG_GATE_INV] &&
            (cfg[`IEE_CFG_FUNC_LSB+1:`IEE_CFG_FUNC_LSB] != `IEE_FUNC_GATE);
      end
   endfunction

   // -----------------------------------------------------------------
   // input filters
   // -----------------------------------------------------------------
   iee_filter #(.CNT_W(CNT_W)) u_flt_a (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin(track_a),
      .hold(hold_cycles(config_reg[`IEE_CFG_FLT_A])),
      .level(a_f)
   );
   iee_filter #(.CNT_W(CNT_W)) u_flt_b (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin(track_b),
      .hold(hold_cycles(config_reg[`IEE_CFG_FLT_B])),
      .level(b_f)
   );
   iee_filter #(.CNT_W(CNT_W)) u_flt_di (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin(aux_digital_input),
      .hold(hold_cycles(config_reg[`IEE_CFG_FLT_DI])),
      .level(di_f)
   );

   // -----------------------------------------------------------------
   // edge detection and configuration fields
   // -----------------------------------------------------------------
   assign eval_mode = config_reg[`IEE_CFG_EVAL_LSB+1:`IEE_CFG_EVAL_LSB];
   assign di_func = config_reg[`IEE_CFG_FUNC_LSB+1:`IEE_CFG_FUNC_LSB];
   assign gate_inv = config_reg[`IEE_CFG_GATE_INV];
   assign b_eff = b_f ^ config_reg[`IEE_CFG_DIR_INV];
   assign a_rise = a_f & ~a_q;
   assign a_fall = ~a_f & a_q;
   assign b_edge = b_f ^ b_q;
   assign di_rise = di_f & ~di_q;
   assign cfg_bad = cfg_invalid(config_reg);
   assign wr_cfg = avs_write && !bus_busy && avs_address == `IEE_REG_CONFIG;
   assign rd_stat = avs_read && !bus_busy && avs_address == `IEE_REG_IRQ_STAT;
   assign stopped_off = master_stop && !config_reg[`IEE_CFG_STOP_CONT];

   // -----------------------------------------------------------------
   // count pulse decode
   // -----------------------------------------------------------------
   always @*
   begin
      next_up = 1'b0;
      next_down = 1'b0;
      dir_down = 1'b0;
      case (eval_mode)
         `IEE_EVAL_PULSE_DIR:
         begin
            // low (unwired) B reads as up; pulse counted on A rising
            dir_down = b_eff;
            next_up = a_rise && !dir_down;
            next_down = a_rise && dir_down;
         end
         `IEE_EVAL_SINGLE:
         begin
            // one A edge pair with B low only
            next_up = a_rise && !b_eff;
            next_down = a_fall && !b_eff;
         end
         `IEE_EVAL_DOUBLE:
         begin
            // both A edges, direction from B
            dir_down = (a_rise && b_eff) || (a_fall && !b_eff);
            next_up = (a_rise || a_fall) && !dir_down;
            next_down = (a_rise || a_fall) && dir_down;
         end
         `IEE_EVAL_QUAD:
         begin
            // every edge of A and B; quadrature assumed from encoder
            if (a_rise || a_fall)
               dir_down = a_f ? b_eff : !b_eff;
            else
               dir_down = b_eff ? !a_f : a_f;
            next_up = (a_rise || a_fall || b_edge) && !dir_down;
            next_down = (a_rise || a_fall || b_edge) && dir_down;
         end
         default:
         begin
            next_up = 1'b0;
            next_down = 1'b0;
         end
      endcase
   end

   // sticky interrupt sources
   assign events = {cfg_bad, sync_pulse, latch_pulse, count_down, count_up};

   // -----------------------------------------------------------------
   // datapath: edge registers, counts, aux function, error flag
   // -----------------------------------------------------------------
   // previous filtered levels, reset to the idle low of the pins
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         di_q <= 1'b0;
      end
      else
      begin
         a_q <= a_f;
         b_q <= b_f;
         di_q <= di_f;
      end
   end

   // one count per clock handles 400 kHz with 50 MHz clock
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         count_up <= 1'b0;
         count_down <= 1'b0;
      end
      else
      begin
         count_up <= next_up && hardware_gate && !stopped_off;
         count_down <= next_down && hardware_gate && !stopped_off;
      end
   end

   // aux function: gate level, latch and sync pulses
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         hardware_gate <= 1'b1;
         latch_pulse <= 1'b0;
         sync_pulse <= 1'b0;
      end
      else
      begin
         // gate closed at master stop in turn-off mode
         if (stopped_off)
            hardware_gate <= 1'b0;
         else if (di_func == `IEE_FUNC_GATE)
            hardware_gate <= di_f ^ gate_inv;
         else
            hardware_gate <= 1'b1;
         // retrigger and sync on rising aux edge
         latch_pulse <= di_rise && di_func == `IEE_FUNC_LATCH && !stopped_off;
         sync_pulse <= di_rise && di_func == `IEE_FUNC_SYNC && !stopped_off &&
            (config_reg[`IEE_CFG_SYNC_PER] || !sync_done);
      end
   end

   // once-only tracking; a pulse wins over a re-arming write
   always @(posedge ref_clk)
   begin
      if (sys_rst)
         sync_done <= 1'b0;
      else if (sync_pulse)
         sync_done <= 1'b1;
      else if (wr_cfg)
         sync_done <= 1'b0;
   end

   // error set on bad config, cleared only by a good assignment
   always @(posedge ref_clk)
   begin
      if (sys_rst)
         param_assign_error <= 1'b0;
      else if (wr_cfg)
         param_assign_error <= cfg_invalid(avs_writedata[`IEE_CFG_W-1:0]);
      else if (cfg_bad)
         param_assign_error <= 1'b1;
   end

   // -----------------------------------------------------------------
   // interrupt status and level output
   // -----------------------------------------------------------------
   // event sets win over the read clear
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         irq_stat <= {`IEE_IRQ_W{1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         if (rd_stat)
            irq_stat <= events;
         else
            irq_stat <= irq_stat | events;
         // level follows status one cycle late
         irq <= |(irq_stat & irq_mask);
      end
   end

   // -----------------------------------------------------------------
   // avalon-mm slave, one wait cycle per access
   // -----------------------------------------------------------------
   // read word of the addressed register
   always @*
   begin
      case (avs_address)
         `IEE_REG_CONFIG: next_readdata = {21'h000000, config_reg};
         `IEE_REG_STATUS: next_readdata = {26'h0000000, param_assign_error,
            hardware_gate, sync_done, di_f, b_f, a_f};
         `IEE_REG_IRQ_STAT: next_readdata = {27'h0000000, irq_stat};
         `IEE_REG_IRQ_MASK: next_readdata = {27'h0000000, irq_mask};
         default: next_readdata = 32'h00000000;
      endcase
   end

   // registers and handshake
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         config_reg <= `IEE_CFG_RESET;
         irq_mask <= {`IEE_IRQ_W{1'b0}};
         avs_readdata <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         bus_busy <= 1'b0;
      end
      else
      begin
         // default: stall, ready for the next request
         avs_waitrequest <= 1'b1;
         bus_busy <= 1'b0;
         if ((avs_read || avs_write) && !bus_busy)
         begin
            avs_waitrequest <= 1'b0;
            bus_busy <= 1'b1;
            if (avs_write)
            begin
               // writes answer zero on the read lines
               avs_readdata <= 32'h00000000;
               if (avs_address == `IEE_REG_CONFIG)
                  config_reg <= avs_writedata[`IEE_CFG_W-1:0];
               else if (avs_address == `IEE_REG_IRQ_MASK)
                  irq_mask <= avs_writedata[`IEE_IRQ_W-1:0];
            end
            else
               avs_readdata <= next_readdata;
         end
      end
   end
endmodule // iee_encoder_eval

// >>> iee_chk.sv
// assertion checker for the encoder evaluation block
`timescale 1ns/1ns
`include "iee_consts.vh"
module iee_chk #(
   parameter CNT_W = 11
) (
   input wire ref_clk,               // clock
   input wire sys_rst,               // reset
   input wire master_stop,           // master stopped
   input wire [3:0] avs_address,     // address
   input wire avs_read,              // read
   input wire avs_write,             // write
   input wire [31:0] avs_writedata,  // write data
   input wire [31:0] avs_readdata,   // read data
   input wire avs_waitrequest,       // stall
   input wire count_up,              // up pulse
   input wire count_down,            // down pulse
   input wire latch_pulse,           // latch pulse
   input wire param_assign_error,    // error flag
   input wire irq                    // interrupt
);
// ------
// config shadow
// ------
reg [`IEE_CFG_W-1:0] cfg_sh;
wire cfg_bad;
wire cfg_wr;
// gate inversion without gate function
assign cfg_bad = cfg_sh[`IEE_CFG_GATE_INV] && (cfg_sh[`IEE_CFG_FUNC_LSB+1:`IEE_CFG_FUNC_LSB] != `IEE_FUNC_GATE);
// config write taken at this edge
assign cfg_wr = avs_write && avs_waitrequest && avs_address == `IEE_REG_CONFIG;
// track config at the edge the block takes it
always @(posedge ref_clk)
begin
   if (sys_rst)
      cfg_sh <= `IEE_CFG_RESET;
   else if (cfg_wr)
      cfg_sh <= avs_writedata[`IEE_CFG_W-1:0];
end
// ------
// properties
// ------
default clocking @(posedge ref_clk); endclocking
default disable iff (sys_rst);
property p_reset_idle;
   disable iff (1'b0) sys_rst |=> avs_waitrequest && !irq && !param_assign_error;
endproperty
a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
property p_wait_one;
   !avs_waitrequest |=> avs_waitrequest;
endproperty
a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
property p_answer;
   $rose(avs_read || avs_write) |=> !avs_waitrequest;
endproperty
a_answer: assert property (p_answer) else $error("no answer after one wait cycle");
property p_unmapped;
   !avs_waitrequest && avs_read && avs_address[3:2] != 2'h0 |-> avs_readdata == 32'h0;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
property p_excl;
   !(count_up && count_down);
endproperty
a_excl: assert property (p_excl) else $error("up and down together");
property p_err_set;
   cfg_bad && $past(cfg_bad) && !cfg_wr |=> param_assign_error;
endproperty
a_err_set: assert property (p_err_set) else $error("bad config not flagged");
property p_err_fall;
   $fell(param_assign_error) |-> !cfg_bad;
endproperty
a_err_fall: assert property (p_err_fall) else $error("error cleared while bad");
property p_latch_one;
   latch_pulse |=> !latch_pulse;
endproperty
a_latch_one: assert property (p_latch_one) else $error("latch pulse too long");
property p_stop_off;
   master_stop && $past(master_stop) && $past(master_stop, 2) && !cfg_sh[`IEE_CFG_STOP_CONT]
      && !$past(cfg_sh[`IEE_CFG_STOP_CONT]) |-> !count_up && !count_down && !latch_pulse;
endproperty
a_stop_off: assert property (p_stop_off) else $error("activity at master stop");
endmodule // iee_chk
bind iee_encoder_eval iee_chk #(.CNT_W(CNT_W)) u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .master_stop(master_stop), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_up(count_up),
   .count_down(count_down), .latch_pulse(latch_pulse), .param_assign_error(param_assign_error), .irq(irq));

// >>> iee_enc_model.sv
// encoder and pulse-direction generator model
`timescale 1ns/1ns
module iee_enc_model (
   input wire ref_clk,  // clock
   output reg track_a,  // track A pin
   output reg track_b   // track B pin
);
reg [1:0] ph = 2'h0;
reg pa = 1'b0;
// pins at rest
initial
begin
   track_a = 1'b0;
   track_b = 1'b0;
end
// direction first, then count track, then steps
task play(input pd, input fwd, input pdb, input integer qtr, input integer steps);
   integer i;
   begin
      track_b <= pd ? pdb : ph[1];
      repeat (2 * qtr) @(posedge ref_clk);
      track_a <= pd ? pa : ph[0] ^ ph[1];
      repeat (qtr) @(posedge ref_clk);
      for (i = 0; i < steps; i = i + 1)
      begin
         pa = ~pa;
         ph = fwd ? ph + 2'h1 : ph - 2'h1;
         track_a <= pd ? pa : ph[0] ^ ph[1];
         track_b <= pd ? pdb : ph[1];
         repeat (qtr) @(posedge ref_clk);
      end
   end
endtask
endmodule // iee_enc_model

// >>> test_iee_encoder_eval.sv
// self-checking bench for the encoder evaluation block
`timescale 1ns/1ns
`include "iee_consts.vh"
module test_iee_encoder_eval;
reg ref_clk, sys_rst, aux_digital_input, master_stop, avs_read, avs_write;
reg [3:0] avs_address;
reg [31:0] avs_writedata, rd;
wire [31:0] avs_readdata;
wire avs_waitrequest, count_up, count_down, hardware_gate, latch_pulse, sync_pulse, param_assign_error, irq;
wire track_a, track_b;
integer errors = 0, checked = 0, n_up = 0, n_dn = 0, n_sy = 0, n_la = 0, e_up, e_dn, i, u0, d0;
reg ba = 1'b0, bb = 1'b0, bpa = 1'b0;
reg [1:0] bph = 2'h0;
reg [15:0] rs = 16'h6AD6;
reg [47:0] aux_cfgs = 48'h0000801C00C0;
iee_encoder_eval DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .track_a(track_a), .track_b(track_b),
   .aux_digital_input(aux_digital_input), .master_stop(master_stop), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .count_up(count_up), .count_down(count_down),
   .hardware_gate(hardware_gate), .latch_pulse(latch_pulse), .sync_pulse(sync_pulse),
   .param_assign_error(param_assign_error), .irq(irq));
iee_enc_model u_enc (.ref_clk(ref_clk), .track_a(track_a), .track_b(track_b));
// ------
// clock and pulse counters
// ------
initial
begin
   ref_clk = 1'b0;
   forever #10 ref_clk = ~ref_clk;
end
always @(posedge ref_clk)
begin
   n_up <= n_up + count_up;
   n_dn <= n_dn + count_down;
   n_sy <= n_sy + sync_pulse;
   n_la <= n_la + latch_pulse;
end
// ------
// helpers
// ------
function [15:0] lf(input [15:0] s);
   lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
// count expected from one level change
function integer dl(input [1:0] m, input pa, input pb, input a, input b);
   case (m)
      `IEE_EVAL_PULSE_DIR: dl = (a && !pa) ? (b ? -1 : 1) : 0;
      `IEE_EVAL_SINGLE: dl = (a != pa && !b) ? (a ? 1 : -1) : 0;
      `IEE_EVAL_DOUBLE: dl = (a != pa) ? ((a != b) ? 1 : -1) : 0;
      default: dl = (a != pa || b != pb) ? (((a != pa) ? a != b : a == b) ? 1 : -1) : 0;
   endcase
endfunction
task close_out;
   begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
endtask
task chk(input [8*12-1:0] nm, input [31:0] e, input [31:0] g);
   begin
      checked = checked + 1;
      if (g !== e)
      begin
         errors = errors + 1;
         $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
   end
endtask
// one bus access, held until waitrequest low
task bus(input we, input [3:0] a, input [31:0] d);
   integer k;
   begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= we;
      avs_read <= !we;
      k = 0;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && k < 20)
      begin
         @(posedge ref_clk);
         k = k + 1;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k == 20)
      begin
         $display("CHECK FAILED bus answer expected 0 seen %0d", k);
         errors = errors + 1;
         close_out;
      end
   end
endtask
task mv(input [1:0] m, input inv, input a, input b);
   integer d;
   begin
      d = dl(m, ba, bb ^ inv, a, b ^ inv);
      e_up = e_up + (d > 0);
      e_dn = e_dn + (d < 0);
      ba = a;
      bb = b;
   end
endtask
// configure, play the tracks, compare counts
task run(input [10:0] cfg, input fwd, input pdb, input integer qtr, input integer steps, input st, input z);
   integer k;
   reg pd;
   begin
      bus(1'b1, `IEE_REG_CONFIG, {21'h0, cfg});
      master_stop <= st;
      pd = (cfg[1:0] == `IEE_EVAL_PULSE_DIR);
      e_up = 0;
      e_dn = 0;
      mv(cfg[1:0], cfg[5], ba, pd ? pdb : bph[1]);
      mv(cfg[1:0], cfg[5], pd ? bpa : bph[0] ^ bph[1], bb);
      for (k = 0; k < steps; k = k + 1)
      begin
         bpa = ~bpa;
         bph = fwd ? bph + 2'h1 : bph - 2'h1;
         mv(cfg[1:0], cfg[5], pd ? bpa : bph[0] ^ bph[1], pd ? pdb : bph[1]);
      end
      u0 = n_up;
      d0 = n_dn;
      u_enc.play(pd, fwd, pdb, qtr, steps);
      repeat (1400) @(posedge ref_clk);
      chk("up count", z ? 0 : e_up, n_up - u0);
      chk("down count", z ? 0 : e_dn, n_dn - d0);
   end
endtask
// ------
// main sequence
// ------
initial
begin
   sys_rst = 1'b1;
   aux_digital_input = 1'b0;
   master_stop = 1'b0;
   avs_read = 1'b0;
   avs_write = 1'b0;
   avs_address = 4'h0;
   avs_writedata = 32'h0;
   repeat (16) @(posedge ref_clk);
   sys_rst <= 1'b0;
   bus(1'b0, `IEE_REG_CONFIG, 32'h0);
   chk("config", 32'h0, rd);
   bus(1'b0, 4'hF, 32'h0);
   chk("unmapped", 32'h0, rd);
   bus(1'b1, `IEE_REG_CONFIG, 32'h200);
   bus(1'b1, `IEE_REG_IRQ_MASK, 32'h10);
   repeat (4) @(posedge ref_clk);
   chk("error", 32'h1, {31'h0, param_assign_error});
   chk("irq", 32'h1, {31'h0, irq});
   bus(1'b1, `IEE_REG_CONFIG, 32'h0);
   bus(1'b0, `IEE_REG_IRQ_STAT, 32'h0);
   chk("irq status", 32'h10, rd);
   bus(1'b0, `IEE_REG_IRQ_STAT, 32'h0);
   chk("irq status", 32'h0, rd);
   repeat (4) @(posedge ref_clk);
   chk("error", 32'h0, {31'h0, param_assign_error});
   chk("irq", 32'h0, {31'h0, irq});
   for (i = 0; i < 4; i = i + 1)
   begin
      bus(1'b1, `IEE_REG_CONFIG, {20'h0, aux_cfgs[12 * i +: 12]});
      u0 = n_sy;
      d0 = n_la;
      repeat (2)
      begin
         aux_digital_input <= 1'b1;
         repeat (300) @(posedge ref_clk);
         aux_digital_input <= 1'b0;
         repeat (300) @(posedge ref_clk);
      end
      chk("sync pulses", (8'h09 >> (2 * i)) & 3, n_sy - u0);
      chk("latch pulses", (8'h20 >> (2 * i)) & 3, n_la - d0);
   end
   bus(1'b1, `IEE_REG_CONFIG, 32'h040);
   repeat (200) @(posedge ref_clk);
   chk("gate shut", 32'h0, {31'h0, hardware_gate});
   aux_digital_input <= 1'b1;
   repeat (200) @(posedge ref_clk);
   chk("gate open", 32'h1, {31'h0, hardware_gate});
   aux_digital_input <= 1'b0;
   bus(1'b1, `IEE_REG_CONFIG, 32'h240);
   repeat (200) @(posedge ref_clk);
   bus(1'b0, `IEE_REG_STATUS, 32'h0);
   chk("status", 32'h10, rd);
   run(11'h040, 1'b1, 1'b0, 150, 6, 1'b0, 1'b1);
   run(11'h000, 1'b1, 1'b0, 150, 6, 1'b0, 1'b0);
   for (i = 0; i < 8; i = i + 1)
   begin
      rs = lf(rs);
      run({5'h0, rs[0], 3'h0, i[1:0]}, rs[1], rs[2], 130 + rs[7:3], 4 + rs[10:8], 1'b0, 1'b0);
   end
   run(11'h004, 1'b1, 1'b0, 1300, 4, 1'b0, 1'b0);
   run(11'h004, 1'b1, 1'b0, 600, 4, 1'b0, 1'b1);
   run(11'h403, 1'b1, 1'b0, 150, 8, 1'b1, 1'b0);
   run(11'h003, 1'b0, 1'b0, 150, 8, 1'b1, 1'b1);
   close_out;
end
endmodule // test_iee_encoder_eval
